// ### hdl/dpra_defines.vh
`ifndef DPRA_DEFINES_VH
`define DPRA_DEFINES_VH
// Function
// - bits 2:1 rank reference, 00 highest
// - bit 0 allows loop to use reference
// - 17-bit bandwidth, 0.1 Hz per count
// - byte three bit 1 picks filter margin
// - 18-bit integer divider holds ratio minus one
// - 24-bit numerator, low byte first
// - zero modulus bypasses fractional divider
// - every writable field resets to zero, applied ratio to one

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define DPRA_IDX_W 11
`define DPRA_IDX_PRIO 11'h440
`define DPRA_IDX_BW_LO 11'h441
`define DPRA_IDX_BW_MID 11'h442
`define DPRA_IDX_BW_HI 11'h443
`define DPRA_IDX_INT_LO 11'h444
`define DPRA_IDX_INT_MID 11'h445
`define DPRA_IDX_INT_HI 11'h446
`define DPRA_IDX_NUM_LO 11'h447
`define DPRA_IDX_NUM_MID 11'h448
`define DPRA_IDX_NUM_HI 11'h449
`define DPRA_IDX_MOD_LO 11'h44A
`define DPRA_IDX_MOD_MID 11'h44B
`define DPRA_IDX_MOD_HI 11'h44C
`define DPRA_IDX_STATUS 11'h44D
`define DPRA_IDX_RATIO_LO 11'h44E
`define DPRA_IDX_RATIO_MID 11'h44F
`define DPRA_IDX_RATIO_HI 11'h450

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DPRA_EN_BIT 0
`define DPRA_PRIO_LSB 1
`define DPRA_PRIO_MSB 2
`define DPRA_BW16_BIT 0
`define DPRA_FILT_BIT 1
`define DPRA_ST_FRAC_BIT 0
`define DPRA_ST_GRANT_BIT 1
`define DPRA_ST_BWZERO_BIT 2
`define DPRA_ST_IMPROPER_BIT 3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DPRA_RST_EN 1'h0
`define DPRA_RST_PRIO 2'h0
`define DPRA_RST_BW 17'h00000
`define DPRA_RST_FILT 1'h0
`define DPRA_RST_INT 18'h00000
`define DPRA_RST_NUM 24'h000000
`define DPRA_RST_MOD 24'h000000
`define DPRA_RST_RATIO 19'h00001

`endif

// ### hdl/dpra_ratio.v
// ---------------------------------------------------------------
// feedback ratio arithmetic
// ---------------------------------------------------------------
module dpra_ratio (
    input wire [17:0] int_field, // stored divider, ratio minus one
    input wire [23:0] numerator, // fractional numerator
    input wire [23:0] modulus, // fractional modulus
    output wire [18:0] ratio_int, // integer part of ratio
    output wire frac_on, // fractional path active
    output wire [23:0] numerator_eff, // numerator as applied
    output wire improper // numerator not below modulus
);

    // integer ratio is the field plus one
    // ratio plus one
    assign ratio_int = {1'b0, int_field} + 19'h00001;

    // zero modulus switches the fraction out
    // modulus zero bypass
    assign frac_on = (modulus != 24'h000000);

    // numerator only contributes while fraction active
    // fraction term
    assign numerator_eff = frac_on ? numerator : 24'h000000;

    // flag for a fraction of one or more
    assign improper = frac_on && (numerator >= modulus);

endmodule // dpra_ratio

// ### hdl/dpra_regs.v
`include "dpra_defines.vh"

module dpra_regs (
    input wire pclk, // apb clock, 20 MHz
    input wire presetn, // async reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, high writes
    input wire [12:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    input wire [3:0] pstrb, // apb byte strobes
    output wire [31:0] prdata, // apb read data
    output wire pready, // apb ready
    output wire pslverr, // apb error on unmapped access
    input wire ref_a_candidate, // loop selector wants reference A
    output wire ref_a_grant, // reference A may be used now
    output wire ref_a_enable, // reference A eligible
    output wire [1:0] ref_a_priority, // reference A rank
    output wire [16:0] loop_bandwidth, // bandwidth in 0.1 Hz steps
    output wire high_margin_filter, // high phase margin filter
    output wire [17:0] integer_feedback_divider, // stored ratio minus one
    output wire [18:0] feedback_ratio_int, // integer ratio applied
    output wire [23:0] fractional_numerator, // numerator as applied
    output wire [23:0] fractional_modulus, // stored modulus
    output wire fractional_enable // fractional divider in use
);

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    reg en_ff;
    reg [1:0] prio_ff;
    reg [16:0] bw_ff;
    reg filt_ff;
    reg [17:0] int_ff;
    reg [23:0] num_ff;
    reg [23:0] mod_ff;
    reg [18:0] ratio_ff;
    reg frac_ff;
    reg [23:0] num_eff_ff;
    reg improper_ff;
    reg grant_ff;
    reg [31:0] prdata_ff;
    reg pready_ff;
    reg pslverr_ff;

    reg nxt_en;
    reg [1:0] nxt_prio;
    reg [16:0] nxt_bw;
    reg nxt_filt;
    reg [17:0] nxt_int;
    reg [23:0] nxt_num;
    reg [23:0] nxt_mod;

    wire [18:0] calc_ratio;
    wire calc_frac;
    wire [23:0] calc_num_eff;
    wire calc_improper;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire [`DPRA_IDX_W-1:0] idx;
    wire aligned;
    wire setup_phase;
    wire wr_take;
    wire [7:0] wbyte;

    assign idx = paddr[12:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup_phase = psel && !penable;
    // write lands only at the edge where ready is sampled high
    assign wr_take = psel && penable && pready_ff && pwrite && !pslverr_ff && pstrb[0];
    assign wbyte = pwdata[7:0];

    // true for any index this block answers
    function mapped;
        input [`DPRA_IDX_W-1:0] i;
        begin
            mapped = (i >= `DPRA_IDX_PRIO) && (i <= `DPRA_IDX_RATIO_HI);
        end
    endfunction

    // true for the read-only indices
    function read_only;
        input [`DPRA_IDX_W-1:0] i;
        begin
            read_only = (i >= `DPRA_IDX_STATUS) && (i <= `DPRA_IDX_RATIO_HI);
        end
    endfunction

    // ---------------------------------------------------------------
    // status byte, read-only view of derived state
    // ---------------------------------------------------------------
    wire [7:0] status_byte;
    wire bw_zero;

    // flags a bandwidth equal to zero, its reset value
    assign bw_zero = (bw_ff == `DPRA_RST_BW);
    assign status_byte[`DPRA_ST_FRAC_BIT] = frac_ff;
    assign status_byte[`DPRA_ST_GRANT_BIT] = grant_ff;
    assign status_byte[`DPRA_ST_BWZERO_BIT] = bw_zero;
    assign status_byte[`DPRA_ST_IMPROPER_BIT] = improper_ff;
    assign status_byte[7:4] = 4'h0;

    // byte view of every register, reserved bits zero
    function [7:0] rd_byte;
        input [`DPRA_IDX_W-1:0] i;
        begin
            case (i)
                `DPRA_IDX_PRIO: rd_byte = {5'h00, prio_ff, en_ff};
                `DPRA_IDX_BW_LO: rd_byte = bw_ff[7:0];
                `DPRA_IDX_BW_MID: rd_byte = bw_ff[15:8];
                `DPRA_IDX_BW_HI: rd_byte = {6'h00, filt_ff, bw_ff[16]};
                `DPRA_IDX_INT_LO: rd_byte = int_ff[7:0];
                `DPRA_IDX_INT_MID: rd_byte = int_ff[15:8];
                `DPRA_IDX_INT_HI: rd_byte = {6'h00, int_ff[17:16]};
                `DPRA_IDX_NUM_LO: rd_byte = num_ff[7:0];
                `DPRA_IDX_NUM_MID: rd_byte = num_ff[15:8];
                `DPRA_IDX_NUM_HI: rd_byte = num_ff[23:16];
                `DPRA_IDX_MOD_LO: rd_byte = mod_ff[7:0];
                `DPRA_IDX_MOD_MID: rd_byte = mod_ff[15:8];
                `DPRA_IDX_MOD_HI: rd_byte = mod_ff[23:16];
                `DPRA_IDX_STATUS: rd_byte = status_byte;
                `DPRA_IDX_RATIO_LO: rd_byte = ratio_ff[7:0];
                `DPRA_IDX_RATIO_MID: rd_byte = ratio_ff[15:8];
                `DPRA_IDX_RATIO_HI: rd_byte = {5'h00, ratio_ff[18:16]};
                default: rd_byte = 8'h00;
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // apb answer: one access cycle, no wait states
    // ---------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup_phase;
            if (setup_phase) begin
                pslverr_ff <= !aligned || !mapped(idx) || (pwrite && read_only(idx));
                prdata_ff <= (!pwrite && aligned) ? {24'h000000, rd_byte(idx)} : 32'h00000000;
            end else if (penable && pready_ff) begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // register write decode
    // ---------------------------------------------------------------
    always @* begin
        nxt_en = en_ff;
        nxt_prio = prio_ff;
        nxt_bw = bw_ff;
        nxt_filt = filt_ff;
        nxt_int = int_ff;
        nxt_num = num_ff;
        nxt_mod = mod_ff;
        if (wr_take) begin
            case (idx)
                `DPRA_IDX_PRIO: begin
                    nxt_en = wbyte[`DPRA_EN_BIT];
                    nxt_prio = wbyte[`DPRA_PRIO_MSB:`DPRA_PRIO_LSB];
                end
                `DPRA_IDX_BW_LO: begin
                    nxt_bw[7:0] = wbyte;
                end
                `DPRA_IDX_BW_MID: begin
                    nxt_bw[15:8] = wbyte;
                end
                `DPRA_IDX_BW_HI: begin
                    nxt_bw[16] = wbyte[`DPRA_BW16_BIT];
                    nxt_filt = wbyte[`DPRA_FILT_BIT];
                end
                `DPRA_IDX_INT_LO: begin
                    nxt_int[7:0] = wbyte;
                end
                `DPRA_IDX_INT_MID: begin
                    nxt_int[15:8] = wbyte;
                end
                `DPRA_IDX_INT_HI: begin
                    nxt_int[17:16] = wbyte[1:0];
                end
                `DPRA_IDX_NUM_LO: begin
                    nxt_num[7:0] = wbyte;
                end
                `DPRA_IDX_NUM_MID: begin
                    nxt_num[15:8] = wbyte;
                end
                `DPRA_IDX_NUM_HI: begin
                    nxt_num[23:16] = wbyte;
                end
                `DPRA_IDX_MOD_LO: begin
                    nxt_mod[7:0] = wbyte;
                end
                `DPRA_IDX_MOD_MID: begin
                    nxt_mod[15:8] = wbyte;
                end
                `DPRA_IDX_MOD_HI: begin
                    nxt_mod[23:16] = wbyte;
                end
                default: begin
                    nxt_en = en_ff;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // configuration storage
    // ---------------------------------------------------------------
    // all fields clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= `DPRA_RST_EN;
            prio_ff <= `DPRA_RST_PRIO;
            bw_ff <= `DPRA_RST_BW;
            filt_ff <= `DPRA_RST_FILT;
            int_ff <= `DPRA_RST_INT;
            num_ff <= `DPRA_RST_NUM;
            mod_ff <= `DPRA_RST_MOD;
        end else begin
            en_ff <= nxt_en;
            prio_ff <= nxt_prio;
            bw_ff <= nxt_bw;
            filt_ff <= nxt_filt;
            int_ff <= nxt_int;
            num_ff <= nxt_num;
            mod_ff <= nxt_mod;
        end
    end

    // ---------------------------------------------------------------
    // applied ratio
    // ---------------------------------------------------------------
    dpra_ratio u_ratio (
        .int_field(int_ff),
        .numerator(num_ff),
        .modulus(mod_ff),
        .ratio_int(calc_ratio),
        .frac_on(calc_frac),
        .numerator_eff(calc_num_eff),
        .improper(calc_improper)
    );

    // ratio terms registered one cycle behind the fields
    // applied ratio
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_ff <= `DPRA_RST_RATIO;
            frac_ff <= 1'b0;
            num_eff_ff <= `DPRA_RST_NUM;
            improper_ff <= 1'b0;
        end else begin
            ratio_ff <= calc_ratio;
            frac_ff <= calc_frac;
            num_eff_ff <= calc_num_eff;
            improper_ff <= calc_improper;
        end
    end

    // ---------------------------------------------------------------
    // reference eligibility gate
    // ---------------------------------------------------------------
    // disabled never granted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_ff <= 1'b0;
        end else begin
            grant_ff <= ref_a_candidate && nxt_en;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign ref_a_grant = grant_ff;
    assign ref_a_enable = en_ff;
    assign ref_a_priority = prio_ff;
    assign loop_bandwidth = bw_ff;
    assign high_margin_filter = filt_ff;
    assign integer_feedback_divider = int_ff;
    assign feedback_ratio_int = ratio_ff;
    assign fractional_numerator = num_eff_ff;
    assign fractional_modulus = mod_ff;
    assign fractional_enable = frac_ff;

endmodule // dpra_regs

// ### sim/dpra_regs_monitor.sv
module dpra_regs_monitor (
    input wire pclk, // clock
    input wire presetn, // reset, low
    input wire psel, // select
    input wire penable, // access
    input wire pwrite, // write
    input wire [12:0] paddr, // address
    input wire [31:0] pwdata, // wdata
    input wire [3:0] pstrb, // strobes
    input wire pready, // ready
    input wire pslverr, // error
    input wire ref_a_candidate, // wanted
    input wire ref_a_grant, // granted
    input wire ref_a_enable, // eligible
    input wire [1:0] ref_a_priority, // rank
    input wire [16:0] loop_bandwidth, // bandwidth
    input wire high_margin_filter, // filter
    input wire [17:0] integer_feedback_divider, // field
    input wire [18:0] feedback_ratio_int, // ratio
    input wire [23:0] fractional_numerator, // numerator
    input wire [23:0] fractional_modulus, // modulus
    input wire fractional_enable // frac on
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // accepted store of byte data
    wire acc = psel && penable && pready && pwrite && !pslverr && pstrb[0];

    a_reset_clear: assert property ($rose(presetn) |-> !ref_a_enable &&
        ref_a_priority == 2'h0 && loop_bandwidth == 17'h0 && fractional_modulus == 24'h0 &&
        integer_feedback_divider == 18'h0 && feedback_ratio_int == 19'h1) else $error("reset");
    a_prio_store: assert property (acc && paddr == 13'h1100 |=>
        {ref_a_priority, ref_a_enable} == $past(pwdata[2:0])) else $error("prio");
    a_grant_gate: assert property (
        ref_a_grant == ($past(ref_a_candidate) && ref_a_enable)) else $error("grant");
    a_bw_low: assert property (acc && paddr == 13'h1104 |=>
        loop_bandwidth[7:0] == $past(pwdata[7:0]) &&
        $stable(loop_bandwidth[16:8])) else $error("bw low");
    a_filter_bit: assert property (acc && paddr == 13'h110C |=>
        {high_margin_filter, loop_bandwidth[16]} == $past(pwdata[1:0])) else $error("filter");
    a_ratio_plus: assert property (
        feedback_ratio_int == {1'h0, $past(integer_feedback_divider)} + 19'h1) else $error("ratio");
    a_frac_enable: assert property (
        fractional_enable == ($past(fractional_modulus) != 24'h0)) else $error("frac");
    a_numer_bypass: assert property ($past(fractional_modulus) == 24'h0 |->
        fractional_numerator == 24'h0) else $error("bypass");
    a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready) else $error("ready");
endmodule // dpra_regs_monitor

bind dpra_regs dpra_regs_monitor u_dpra_regs_monitor (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .ref_a_candidate, .ref_a_grant,
    .ref_a_enable, .ref_a_priority, .loop_bandwidth, .high_margin_filter,
    .integer_feedback_divider, .feedback_ratio_int, .fractional_numerator,
    .fractional_modulus, .fractional_enable);

// ### sim/dpll_ref_a_profile_regs_test.sv
module dpll_ref_a_profile_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    reg ref_a_candidate = 1'h0, rerr, cand_q = 1'h0;
    reg [12:0] paddr = 13'h0;
    reg [31:0] pwdata = 32'h0, rdat;
    reg [3:0] pstrb = 4'h0;
    reg [7:0] m [0:12];
    reg [7:0] d;
    reg [23:0] num, mdl;
    integer seed = 32'ha4bb, miscompares = 0, checked = 0, cyc = 0, i, k;
    wire [31:0] prdata;
    wire [16:0] bw;
    wire [17:0] intf;
    wire [18:0] ratio;
    wire [23:0] fnum, fmod;
    wire [1:0] prio;
    wire pready, pslverr, grant, en, filt, fen;

    dpra_regs u_dpra_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_a_candidate(ref_a_candidate),
        .ref_a_grant(grant), .ref_a_enable(en), .ref_a_priority(prio),
        .loop_bandwidth(bw), .high_margin_filter(filt), .integer_feedback_divider(intf),
        .feedback_ratio_int(ratio), .fractional_numerator(fnum),
        .fractional_modulus(fmod), .fractional_enable(fen));

    // clock, random candidate, hang limit
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        ref_a_candidate <= $random(seed);
        cand_q <= ref_a_candidate;
        if (cyc == 8000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [7:0] msk(input integer j);
        msk = (j == 0) ? 8'h07 : (j == 3 || j == 6) ? 8'h03 : 8'hFF;
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, waits for ready
    task apb(input w, input [10:0] idx, input [7:0] d, input [3:0] st);
        reg [31:0] r;
        r = $random(seed);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {r[31:8], d};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wrm(input integer j, input [7:0] d);
        apb(1'h1, 11'h440 + j, d, 4'hF);
        chk(rerr, 32'h0);
        m[j] = d & msk(j);
    endtask
    task rdm(input integer j);
        apb(1'h0, 11'h440 + j, 8'h0, 4'h0);
        chk(rdat, {24'h0, m[j]});
    endtask
    task outs;
        repeat (2) @(posedge pclk);
        num = {m[9], m[8], m[7]};
        chk(grant, cand_q & m[0][0]);
        mdl = {m[12], m[11], m[10]};
        chk(en, m[0][0]);
        chk(prio, m[0][2:1]);
        chk(bw, {m[3][0], m[2], m[1]});
        chk(filt, m[3][1]);
        chk(intf, {m[6][1:0], m[5], m[4]});
        chk(ratio, {m[6][1:0], m[5], m[4]} + 32'h1);
        chk(fmod, mdl);
        chk(fen, mdl != 24'h0);
        chk(fnum, (mdl != 24'h0) ? num : 24'h0);
    endtask
    // reset, then every writable register reads zero, outputs checked, ratio one
    task reset_check;
        presetn <= 1'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        for (k = 0; k < 13; k = k + 1) m[k] = 8'h0;
        for (k = 0; k < 13; k = k + 1) rdm(k);
        outs;
    endtask
    task final_report;
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset_check;
        for (i = 0; i < 4; i = i + 1) begin
            wrm(0, {i[1:0], 1'h1});
            outs;
        end
        // numerator hidden while modulus zero, then full integer field
        wrm(7, 8'h5A);
        outs;
        wrm(10, 8'h01);
        for (i = 4; i < 7; i = i + 1) wrm(i, 8'hFF);
        wrm(2, 8'h10);
        wrm(3, 8'h02);
        outs;
        repeat (40) begin
            i = $unsigned($random(seed)) % 13;
            d = $random(seed);
            if (i == 2) d = (d & 8'h7F) | 8'h02;
            if (i == 3) d = d & 8'hFE;
            wrm(i, d);
            rdm(i);
            outs;
        end
        // refused and ignored accesses leave the bank alone
        apb(1'h1, 11'h44D, 8'hFF, 4'hF);
        chk(rerr, 32'h1);
        apb(1'h0, 11'h451, 8'h0, 4'h0);
        chk(rerr, 32'h1);
        chk(rdat, 32'h0);
        apb(1'h1, 11'h440, ~m[0], 4'h0);
        chk(rerr, 32'h0);
        rdm(0);
        outs;
        // applied ratio bytes read back
        k = {m[6][1:0], m[5], m[4]} + 32'h1;
        for (i = 0; i < 3; i = i + 1) begin
            apb(1'h0, 11'h44E + i, 8'h0, 4'h0);
            chk(rdat, (k >> (8 * i)) & 32'hFF);
        end
        reset_check;
        final_report;
    end
endmodule // dpll_ref_a_profile_regs_test
